// *** core/asc_channel.sv ***
// asynchronous serial channel with avalon register slave
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module asc_channel (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_tx_bit_clock,
  input wire logic i_rx_bit_clock,
  input wire logic i_rxd,
  input wire logic i_cts_n,
  input wire logic i_carrier_detect_in_n,
  input wire logic i_sync_n,
  output logic o_txd,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_wait_ready_n,
  output logic o_int
);
  asc_pkg::asc_chan_s q, d;
  asc_pkg::asc_entry_s head, ent;
  logic [1:0] qcnt;
  logic rx_push, rx_pop, err_rst;
  logic [5:0] pins;

  assign pins = {i_rx_bit_clock, i_tx_bit_clock, i_rxd,
                 i_cts_n, i_carrier_detect_in_n, i_sync_n};

  // queue keeps data and flags side by side
  asc_rx_queue u_rxq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_push(rx_push),
    .i_entry(ent),
    .i_pop(rx_pop),
    .o_head(head),
    .o_count(qcnt)
  );

  // next-state logic for the whole channel
  always_comb begin
    logic [7:0] div, half, stop_t, msk, rdv, vecv;
    logic [3:0] tlen, rlen, nbits;
    logic pen, tick_t, tick_r, rxd, rxa, rxi, spc, ext_chg;
    logic [10:0] fr;
    div = asc_pkg::div_of(q.mode[7:6]); // [RULE20]
    half = div >> 1;
    tlen = asc_pkg::len_of(q.tx_bit_clock[6:5]); // [RULE22]
    rlen = asc_pkg::len_of(q.rx_bit_clock[7:6]); // [RULE19]
    pen = q.mode[asc_pkg::MODE_PEN]; // [RULE21]
    nbits = rlen + {3'h0, pen};
    msk = ~(8'hFF << tlen);
    fr = '1;
    rdv = 8'h00;
    vecv = q.vec;
    d = q;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    err_rst = 1'b0;
    ent = '0;

    // three-stage pin filter: a level counts once stages two and three agree
    for (int i = 0; i < asc_pkg::PINS; i++) begin
      d.sy[i] = {q.sy[i][1:0], pins[i]};
      if (q.sy[i][1] == q.sy[i][2]) begin
        d.pin[i] = q.sy[i][2];
      end
    end
    tick_t = q.pin[asc_pkg::P_TXC] & ~d.pin[asc_pkg::P_TXC]; // [RULE8]
    tick_r = ~q.pin[asc_pkg::P_RXC] & d.pin[asc_pkg::P_RXC]; // [RULE12]
    rxd = d.pin[asc_pkg::P_RXD];
    ext_chg = |((d.pin ^ q.pin) & asc_pkg::EXT_MASK);

    // stop time in bit-clock ticks; x1 has no half bit so 1.5 rounds to 1
    case (q.mode[3:2])
      asc_pkg::STOP_1H: stop_t = div + half; // [RULE21]
      asc_pkg::STOP_2: stop_t = div << 1;
      default: stop_t = div;
    endcase

    // status seen by software and by the interrupt logic
    rxa = qcnt != 2'h0; // [RULE23]
    rxi = rxa && q.itc[4:3] != 2'h0;
    spc = rxi && (head.frm || head.ovr);
    if (q.itc[asc_pkg::ITC_SAV]) begin
      if (spc) begin
        vecv[3:1] = asc_pkg::VEC_SPC; // [RULE18]
      end else if (rxi) begin
        vecv[3:1] = asc_pkg::VEC_RX;
      end else if (q.txe_pend) begin
        vecv[3:1] = asc_pkg::VEC_TX;
      end else if (q.ext_pend) begin
        vecv[3:1] = asc_pkg::VEC_EXT;
      end
    end

    // transmitter: frame built once at load, shifted on falling edges
    case (q.tst)
      asc_pkg::TX_IDLE: begin
        if (q.tfull && q.tx_bit_clock[asc_pkg::TXC_EN] && // [RULE3]
            (!q.rx_bit_clock[asc_pkg::RXC_AUTO] ||
             !d.pin[asc_pkg::P_CTS])) begin // [RULE4]
          fr[0] = 1'b0; // [RULE7]
          for (int i = 0; i < 8; i++) begin
            if (4'(i) < tlen) begin
              fr[i+1] = q.tbuf[i];
            end
          end
          if (pen) begin
            fr[tlen+4'h1] = ^(q.tbuf & msk) ^ ~q.mode[asc_pkg::MODE_EVEN];
          end
          d.tsh = fr;
          d.tbits = tlen + 4'h1 + {3'h0, pen};
          d.tfull = 1'b0;
          d.txe_pend = q.txe_pend | q.itc[asc_pkg::ITC_TXI];
          d.ttick = 8'h00;
          d.tst = asc_pkg::TX_BITS;
        end
      end
      asc_pkg::TX_BITS: begin
        if (tick_t) begin
          if (q.ttick == 8'h00) begin
            d.txbit = q.tsh[0];
          end
          if (q.ttick == div - 8'h01) begin // [RULE8]
            d.ttick = 8'h00;
            d.tsh = q.tsh >> 1;
            d.tbits = q.tbits - 4'h1;
            if (q.tbits == 4'h1) begin
              d.tst = asc_pkg::TX_STOP;
            end
          end else begin
            d.ttick = q.ttick + 8'h01;
          end
        end
      end
      asc_pkg::TX_STOP: begin
        if (tick_t) begin
          if (q.ttick == 8'h00) begin
            d.txbit = 1'b1;
          end
          if (q.ttick >= stop_t - 8'h01) begin // [RULE7]
            d.ttick = 8'h00;
            d.tst = asc_pkg::TX_IDLE;
          end else begin
            d.ttick = q.ttick + 8'h01;
          end
        end
      end
      default: d.tst = asc_pkg::TX_IDLE;
    endcase
    // break overrides everything; idle line marks high
    if (q.tx_bit_clock[asc_pkg::TXC_BRK]) begin
      d.txd = 1'b0; // [RULE6]
    end else if (q.tst == asc_pkg::TX_IDLE) begin
      d.txd = 1'b1; // [RULE5]
    end else begin
      d.txd = q.txbit;
    end
    d.rts_n = ~q.tx_bit_clock[asc_pkg::TXC_RTS];
    d.dtr_n = ~q.tx_bit_clock[asc_pkg::TXC_DTR];

    // read mux; write-only registers read as zero
    case (i_address)
      asc_pkg::OFF_DATA: rdv = head.data;
      asc_pkg::OFF_STAT: rdv = {2'h0, ~q.pin[asc_pkg::P_CTS],
                                ~q.pin[asc_pkg::P_SYNC],
                                ~q.pin[asc_pkg::P_CD],
                                ~q.tfull, q.irq, rxa}; // [RULE24]
      asc_pkg::OFF_ERR: rdv = {1'b0, head.frm & rxa, q.ovr_l,
                               q.par_l, 3'h0,
                               q.tst == asc_pkg::TX_IDLE}; // [RULE16]
      asc_pkg::OFF_VEC: rdv = vecv;
      default: rdv = 8'h00;
    endcase

    // avalon slave: one wait cycle, then the access completes
    if (!q.wr) begin
      d.wr = 1'b1;
      if (i_write) begin
        case (i_address)
          asc_pkg::OFF_DATA: begin
            d.tbuf = i_writedata[7:0];
            d.tfull = 1'b1;
            d.txe_pend = 1'b0;
          end
          asc_pkg::OFF_CMD: begin
            if (i_writedata[asc_pkg::CMD_ERST]) begin
              err_rst = 1'b1;
              d.par_l = 1'b0;
              d.ovr_l = 1'b0;
            end
            if (i_writedata[asc_pkg::CMD_XRST]) begin
              d.ext_pend = 1'b0;
            end
          end
          asc_pkg::OFF_ITC: d.itc = i_writedata[7:0];
          asc_pkg::OFF_VEC: d.vec = i_writedata[7:0];
          asc_pkg::OFF_RXC: d.rx_bit_clock = i_writedata[7:0] & asc_pkg::RXC_MASK;
          asc_pkg::OFF_MODE: d.mode = i_writedata[7:0] & asc_pkg::MODE_MASK;
          asc_pkg::OFF_TXC: d.tx_bit_clock = i_writedata[7:0];
          default: d.wr = 1'b1;
        endcase
      end else if (i_read && i_address == asc_pkg::OFF_DATA) begin
        rx_pop = rxa;
      end
    end else if (i_read || i_write) begin
      d.wr = 1'b0;
      d.rdata = rdv;
    end

    // receiver: start check, mid-bit sampling, stop check
    if (!q.rx_bit_clock[asc_pkg::RXC_EN]) begin
      d.rst = asc_pkg::RX_IDLE;
    end else begin
      case (q.rst)
        asc_pkg::RX_IDLE: begin
          if (tick_r && !rxd && (!q.rx_bit_clock[asc_pkg::RXC_AUTO] ||
              !d.pin[asc_pkg::P_CD])) begin // [RULE10]
            d.rsh = 8'hFF; // [RULE13]
            d.ridx = 4'h0;
            d.rpar = 1'b0;
            d.rtick = 8'h01;
            d.rst = (div == 8'h01) ? asc_pkg::RX_DATA : asc_pkg::RX_START;
            if (div == 8'h01) begin
              d.rtick = 8'h00; // [RULE12]
            end
          end
        end
        asc_pkg::RX_START: begin
          // a spike shorter than half a bit is dropped
          if (tick_r) begin
            if (rxd) begin
              d.rst = asc_pkg::RX_IDLE;
            end else if (q.rtick + 8'h01 >= half) begin // [RULE11]
              d.rtick = 8'h00;
              d.rst = asc_pkg::RX_DATA;
            end else begin
              d.rtick = q.rtick + 8'h01;
            end
          end
        end
        asc_pkg::RX_DATA: begin
          if (tick_r) begin
            if (q.rtick == div - 8'h01) begin // [RULE11]
              d.rtick = 8'h00;
              if (q.ridx < nbits) begin
                if (q.ridx < 4'h8) begin
                  d.rsh[q.ridx[2:0]] = rxd; // [RULE13]
                end
                d.rpar = q.rpar ^ rxd;
                d.ridx = q.ridx + 4'h1;
              end else begin
                ent.data = q.rsh;
                ent.par = pen & (q.rpar ^ ~q.mode[asc_pkg::MODE_EVEN]);
                ent.frm = !rxd; // [RULE16]
                rx_push = 1'b1; // [RULE14]
                d.par_l = d.par_l | ent.par; // [RULE15]
                d.rst = rxd ? asc_pkg::RX_IDLE : asc_pkg::RX_HOLD;
              end
            end else begin
              d.rtick = q.rtick + 8'h01;
            end
          end
        end
        asc_pkg::RX_HOLD: begin
          // extra half bit so a low stop bit is not a new start
          if (tick_r) begin
            if (q.rtick + 8'h01 >= half) begin // [RULE16]
              d.rst = asc_pkg::RX_IDLE;
            end else begin
              d.rtick = q.rtick + 8'h01;
            end
          end
        end
        default: d.rst = asc_pkg::RX_IDLE;
      endcase
    end
    if (rx_push && qcnt == asc_pkg::RXQ_FULL && !rx_pop) begin
      d.ovr_l = 1'b1; // [RULE17]
    end
    // sets come after the clears above so a same-cycle event wins
    if (q.itc[asc_pkg::ITC_EXT] && ext_chg) begin
      d.ext_pend = 1'b1; // [RULE9]
    end
    d.irq = spc | rxi | q.txe_pend | q.ext_pend; // [RULE18]

    // wait/ready pin: ready drives low when able, wait drives low when not
    if (!q.itc[asc_pkg::ITC_WEN]) begin
      d.wrdy_n = 1'b1;
    end else if (q.itc[asc_pkg::ITC_WRX]) begin
      d.wrdy_n = q.itc[asc_pkg::ITC_WFN] ? !rxa : rxa; // [RULE1]
    end else begin
      d.wrdy_n = q.itc[asc_pkg::ITC_WFN] ? q.tfull : !q.tfull; // [RULE1]
    end
  end

  // single state register; control fields clear to zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.wr <= 1'b1;
      q.txd <= 1'b1;
      q.txbit <= 1'b1;
      q.rts_n <= 1'b1;
      q.dtr_n <= 1'b1;
      q.wrdy_n <= 1'b1;
      q.pin <= '1;
      q.sy <= '1;
      q.itc <= asc_pkg::CFG_RST;
      q.rx_bit_clock <= asc_pkg::CFG_RST;
      q.mode <= asc_pkg::CFG_RST;
      q.tx_bit_clock <= asc_pkg::CFG_RST;
    end else begin
      q <= d;
    end
  end

  assign o_readdata = {24'h000000, q.rdata};
  assign o_waitrequest = q.wr;
  assign o_txd = q.txd;
  assign o_rts_n = q.rts_n;
  assign o_dtr_n = q.dtr_n;
  assign o_wait_ready_n = q.wrdy_n;
  assign o_int = q.irq;

  // checks on the design's own behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_data_wr;
    i_write && !o_waitrequest && i_address == asc_pkg::OFF_DATA;
  endsequence
  sequence s_ack;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  bus_answer_a: assert property ((i_read || i_write) && o_waitrequest
    |=> s_ack) else $error("bus answer not one cycle");
  break_low_a: assert property (q.tx_bit_clock[asc_pkg::TXC_BRK] |=> !o_txd) // [RULE6]
    else $error("break not driving line low");
  idle_mark_a: assert property ((q.tst == asc_pkg::TX_IDLE && // [RULE5]
    !q.tx_bit_clock[asc_pkg::TXC_BRK]) |=> o_txd) else $error("idle line not high");
  tx_enable_a: assert property ((q.tst == asc_pkg::TX_IDLE && // [RULE3]
    !q.tx_bit_clock[asc_pkg::TXC_EN]) |=> q.tst == asc_pkg::TX_IDLE)
    else $error("transmit started while disabled");
  cts_gate_a: assert property ((q.tst == asc_pkg::TX_IDLE && // [RULE4]
    q.rx_bit_clock[asc_pkg::RXC_AUTO] && d.pin[asc_pkg::P_CTS])
    |=> q.tst == asc_pkg::TX_IDLE) else $error("sent without cts");
  rx_enable_a: assert property ((q.rst == asc_pkg::RX_IDLE && // [RULE10]
    !q.rx_bit_clock[asc_pkg::RXC_EN]) |=> q.rst == asc_pkg::RX_IDLE)
    else $error("receive started while disabled");
  overrun_a: assert property ((rx_push && qcnt == asc_pkg::RXQ_FULL // [RULE17]
    && !rx_pop) |=> q.ovr_l) else $error("overrun not latched");
  parity_hold_a: assert property ((q.par_l && !err_rst) // [RULE15]
    |=> q.par_l) else $error("parity error dropped early");
  tx_full_a: assert property (s_data_wr |=> q.tfull) // [RULE24]
    else $error("buffer not full after write");
  ready_rx_a: assert property ((q.itc[7:5] == 3'h7 && qcnt != 2'h0) // [RULE1]
    |=> !o_wait_ready_n) else $error("ready not shown");
  short_char_a: assert property ((rx_push && q.rx_bit_clock[7:6] == 2'h0 && // [RULE13]
    !q.mode[asc_pkg::MODE_PEN]) |-> ent.data[7:5] == 3'h7)
    else $error("upper bits not filled with ones");
endmodule

// *** core/asc_pkg.sv ***
// async serial channel: shared constants, types and decode functions
// What this block does
// [RULE1] one wait/ready pin, role chosen by control bits 5, 6 and 7
// [RULE2] software writes mode_parameters before the other control registers
// [RULE3] transmitter sends nothing until transmit enable is set
// [RULE4] with auto enables, a loaded character waits for clear-to-send low
// [RULE5] transmit line idles high when no character is pending
// [RULE6] send break holds transmit line low until the bit is cleared
// [RULE7] each character gets start bit, chosen parity and chosen stop bits; at x1 the code sends 1 stop bit when 1.5 is chosen
// [RULE8] one bit per 1/16/32/64 transmit clocks, changing on falling edge
// [RULE9] external/status interrupt on a lasting change of cd, cts or sync
// [RULE10] receive needs receive enable, and carrier low under auto enables
// [RULE11] start bit valid after half a bit low, then mid-bit sampling
// [RULE12] divide-by-one mode samples on rising receive clock edge
// [RULE13] short characters: data low, parity kept, ones above
// [RULE14] three-deep receive queue, error flags stored with each character
// [RULE15] parity error bit 4 latched until error reset command
// [RULE16] framing error bit 6 per character, plus half bit of delay
// [RULE17] fourth character overwrites newest entry, latches overrun bit 5
// [RULE18] framing error or overrun gives special receive vector
// [RULE19] receive_control: length 7-6, auto enables 5, enable 0
// [RULE20] mode_parameters: clock divisor in bits 7-6, bits 5-4 zero
// [RULE21] mode_parameters: stop bits 3-2, parity sense 1, parity enable 0
// [RULE22] transmit_control: dtr 7, length 6-5, break 4, enable 3, rts 1
// [RULE23] character available set while queued, clears when queue empty
// [RULE24] transmit buffer empty bit is one while the buffer holds nothing
package asc_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_DATA = 6'h00;
  localparam logic [5:0] OFF_STAT = 6'h04;
  localparam logic [5:0] OFF_ERR = 6'h08;
  localparam logic [5:0] OFF_CMD = 6'h0C;
  localparam logic [5:0] OFF_ITC = 6'h10;
  localparam logic [5:0] OFF_VEC = 6'h14;
  localparam logic [5:0] OFF_RXC = 6'h18;
  localparam logic [5:0] OFF_MODE = 6'h1C;
  localparam logic [5:0] OFF_TXC = 6'h20;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RXC_MASK = 8'hE1;
  localparam logic [7:0] MODE_MASK = 8'hCF;
  // bit positions
  localparam int RXC_EN = 0;
  localparam int RXC_AUTO = 5;
  localparam int TXC_RTS = 1;
  localparam int TXC_EN = 3;
  localparam int TXC_BRK = 4;
  localparam int TXC_DTR = 7;
  localparam int MODE_PEN = 0;
  localparam int MODE_EVEN = 1;
  localparam int ITC_EXT = 0;
  localparam int ITC_TXI = 1;
  localparam int ITC_SAV = 2;
  localparam int ITC_WRX = 5;
  localparam int ITC_WFN = 6;
  localparam int ITC_WEN = 7;
  localparam int CMD_ERST = 0;
  localparam int CMD_XRST = 1;
  localparam logic [1:0] STOP_1H = 2'h2;
  localparam logic [1:0] STOP_2 = 2'h3;
  localparam logic [2:0] VEC_TX = 3'h4;
  localparam logic [2:0] VEC_EXT = 3'h5;
  localparam logic [2:0] VEC_RX = 3'h6;
  localparam logic [2:0] VEC_SPC = 3'h7;
  localparam int RXQ_DEPTH = 3;
  localparam logic [1:0] RXQ_FULL = 2'h3;
  // synchronised pin indices
  localparam int PINS = 6;
  localparam int P_SYNC = 0;
  localparam int P_CD = 1;
  localparam int P_CTS = 2;
  localparam int P_RXD = 3;
  localparam int P_TXC = 4;
  localparam int P_RXC = 5;
  localparam logic [5:0] EXT_MASK = 6'h07;

  typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_STOP} asc_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_HOLD} asc_rx_e;

  typedef struct packed {
    logic frm;
    logic ovr;
    logic par;
    logic [7:0] data;
  } asc_entry_s;

  typedef struct packed {
    logic [5:0][2:0] sy;
    logic [5:0] pin;
    logic wr;
    logic [7:0] rdata;
    logic [7:0] itc, vec, rx_bit_clock, mode, tx_bit_clock;
    asc_tx_e tst;
    logic [7:0] tbuf;
    logic tfull, txe_pend, txbit, txd, rts_n, dtr_n;
    logic [10:0] tsh;
    logic [3:0] tbits;
    logic [7:0] ttick;
    asc_rx_e rst;
    logic [7:0] rsh;
    logic [3:0] ridx;
    logic [7:0] rtick;
    logic rpar, par_l, ovr_l, ext_pend, irq, wrdy_n;
  } asc_chan_s;

  // character length field: 00 five, 10 six, 01 seven, 11 eight
  function automatic logic [3:0] len_of(input logic [1:0] f);
    case (f)
      2'h0: len_of = 4'h5;
      2'h2: len_of = 4'h6;
      2'h1: len_of = 4'h7;
      default: len_of = 4'h8;
    endcase
  endfunction

  // clock divisor field: 00 x1, 01 x16, 10 x32, 11 x64
  function automatic logic [7:0] div_of(input logic [1:0] f);
    case (f)
      2'h0: div_of = 8'h01;
      2'h1: div_of = 8'h10;
      2'h2: div_of = 8'h20;
      default: div_of = 8'h40;
    endcase
  endfunction
endpackage

// *** core/asc_rx_queue.sv ***
// three-entry receive queue with flags and a registered head output
`timescale 1ns/10ps
module asc_rx_queue (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_push,
  input asc_pkg::asc_entry_s i_entry,
  input wire logic i_pop,
  output asc_pkg::asc_entry_s o_head,
  output logic [1:0] o_count
);
  typedef struct packed {
    asc_pkg::asc_entry_s [asc_pkg::RXQ_DEPTH-1:0] mem;
    logic [1:0] count;
    asc_pkg::asc_entry_s head;
  } asc_q_s;

  asc_q_s q, d;

  // pop shifts toward slot 0; a push into a full queue replaces the newest
  always_comb begin
    asc_pkg::asc_entry_s [asc_pkg::RXQ_DEPTH-1:0] m;
    logic [1:0] n;
    m = q.mem;
    n = q.count;
    d = q;
    if (i_pop && n != 2'h0) begin
      for (int i = 0; i < asc_pkg::RXQ_DEPTH - 1; i++) begin
        m[i] = m[i+1];
      end
      n = n - 2'h1;
    end
    if (i_push) begin
      if (n == asc_pkg::RXQ_FULL) begin
        m[asc_pkg::RXQ_DEPTH-1] = i_entry; // [RULE17]
        m[asc_pkg::RXQ_DEPTH-1].ovr = 1'b1;
      end else begin
        m[n] = i_entry; // [RULE14]
        n = n + 2'h1;
      end
    end
    d.mem = m;
    d.count = n;
    d.head = m[0];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_head = q.head;
  assign o_count = q.count;
endmodule

// *** verification/asc_line_model.sv ***
// serial line model: free-running bit clocks, receive driver, tx sampler
`timescale 1ns/10ps
module asc_line_model (
  input wire logic i_txd,
  output logic o_tx_bit_clock,
  output logic o_rx_bit_clock,
  output logic o_rxd
);
  // baud clocks run free; offsets keep their edges off the system clock
  initial begin
    o_tx_bit_clock = 1'b1;
    #170;
    forever #500 o_tx_bit_clock = ~o_tx_bit_clock;
  end
  initial begin
    o_rx_bit_clock = 1'b1;
    o_rxd = 1'b1;
    #230;
    forever #500 o_rx_bit_clock = ~o_rx_bit_clock;
  end

  // n line bits lsb first, 16 receive clocks each, then a mark bit
  task automatic send_bits(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      o_rxd = bits[i];
      repeat (16) @(posedge o_rx_bit_clock);
    end
    o_rxd = 1'b1;
    repeat (16) @(posedge o_rx_bit_clock);
  endtask

  // x1: we must give bit sync, so change data on falling edges
  task automatic send_x1(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge o_rx_bit_clock);
      o_rxd = bits[i];
    end
    @(negedge o_rx_bit_clock);
    o_rxd = 1'b1;
    repeat (4) @(posedge o_rx_bit_clock);
  endtask

  // low pulse shorter than half a bit, must not start a character
  task automatic glitch;
    o_rxd = 1'b0;
    repeat (3) @(posedge o_rx_bit_clock);
    o_rxd = 1'b1;
    repeat (32) @(posedge o_rx_bit_clock);
  endtask

  // sample start and n-1 bits at mid-bit, 16 tx clocks apart
  task automatic take_bits(input int n, output logic [11:0] bits);
    bits = 12'h000;
    @(negedge i_txd);
    repeat (8) @(posedge o_tx_bit_clock);
    bits[0] = i_txd;
    for (int i = 1; i < n; i++) begin
      repeat (16) @(posedge o_tx_bit_clock);
      bits[i] = i_txd;
    end
  endtask
endmodule

// *** verification/async_serial_channel_test.sv ***
// self-checking bench for the asynchronous serial channel
`timescale 1ns/10ps
module async_serial_channel_test;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [5:0] i_address = 6'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic i_cts_n = 1'b0;
  logic i_carrier_detect_in_n = 1'b0;
  logic i_sync_n = 1'b1;
  logic [31:0] o_readdata;
  logic o_waitrequest, o_txd, o_rts_n, o_dtr_n, o_wait_ready_n, o_int;
  logic tx_clk, rx_clk, rxd;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] rd;
  logic [11:0] cap;

  // 10 MHz system clock
  always #50 i_clk = ~i_clk;

  asc_channel DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_tx_bit_clock(tx_clk), .i_rx_bit_clock(rx_clk), .i_rxd(rxd),
    .i_cts_n(i_cts_n), .i_carrier_detect_in_n(i_carrier_detect_in_n),
    .i_sync_n(i_sync_n), .o_txd(o_txd), .o_rts_n(o_rts_n),
    .o_dtr_n(o_dtr_n), .o_wait_ready_n(o_wait_ready_n), .o_int(o_int));

  asc_line_model LINE (.i_txd(o_txd), .o_tx_bit_clock(tx_clk),
    .o_rx_bit_clock(rx_clk), .o_rxd(rxd));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= {24'h000000, d};
    i_write <= wr;
    i_read <= ~wr;
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0) @(posedge i_clk);
    rd = o_readdata[7:0];
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd, exp);
  endtask

  task automatic stat(input logic [7:0] m, input logic [7:0] exp);
    bus(1'b0, asc_pkg::OFF_STAT, 8'h00);
    check(rd & m, exp);
  endtask

  task automatic err(input logic [7:0] m, input logic [7:0] exp);
    bus(1'b0, asc_pkg::OFF_ERR, 8'h00);
    check(rd & m, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // mode first, then receive and transmit control
  task automatic cfg(input logic [7:0] m, input logic [7:0] r,
                     input logic [7:0] t);
    bus(1'b1, asc_pkg::OFF_MODE, m);
    bus(1'b1, asc_pkg::OFF_RXC, r);
    bus(1'b1, asc_pkg::OFF_TXC, t);
  endtask

  task automatic t_reset;
    wt(2);
    check({7'h00, o_txd}, 8'h01); // line at mark
    check({6'h00, o_rts_n, o_dtr_n}, 8'h03); // modem outputs off
    rdc(6'h3C, 8'h00); // unmapped place reads zero
    rdc(asc_pkg::OFF_MODE, 8'h00); // write-only reads zero
    $display("test reset done");
  endtask

  task automatic t_tx_enable;
    cfg(8'h44, 8'hC1, 8'hE2);
    bus(1'b1, asc_pkg::OFF_DATA, 8'hA5);
    wt(400);
    check({7'h00, o_txd}, 8'h01); // held while disabled
    stat(8'h04, 8'h00); // buffer occupied
    bus(1'b1, asc_pkg::OFF_TXC, 8'hEA);
    check({6'h00, o_rts_n, o_dtr_n}, 8'h00); // modem outputs on
    LINE.take_bits(10, cap);
    check(cap[8:1], 8'hA5); // data lsb first at x16
    check({6'h00, cap[9], cap[0]}, 8'h02); // start low, stop high
    stat(8'h04, 8'h04); // buffer empty again
    $display("test tx enable done");
  endtask

  task automatic t_tx_parity;
    cfg(8'h47, 8'h41, 8'hAA);
    bus(1'b1, asc_pkg::OFF_DATA, 8'hD5);
    LINE.take_bits(10, cap);
    check({1'b0, cap[7:1]}, 8'h55); // top bit dropped
    check({6'h00, cap[8], cap[9]}, 8'h01); // even parity, stop
    $display("test tx parity done");
  endtask

  task automatic t_auto_break;
    wt(1);
    i_cts_n <= 1'b1;
    cfg(8'h44, 8'hE1, 8'hEA);
    bus(1'b1, asc_pkg::OFF_DATA, 8'h3C);
    wt(400);
    check({7'h00, o_txd}, 8'h01); // waits for clear-to-send
    i_cts_n <= 1'b0;
    LINE.take_bits(10, cap);
    check(cap[8:1], 8'h3C); // sent once clear
    bus(1'b1, asc_pkg::OFF_TXC, 8'hFA);
    wt(40);
    check({7'h00, o_txd}, 8'h00); // break holds space
    bus(1'b1, asc_pkg::OFF_TXC, 8'hEA);
    wt(40);
    check({7'h00, o_txd}, 8'h01); // back to mark
    $display("test auto and break done");
  endtask

  task automatic t_rx;
    bus(1'b1, asc_pkg::OFF_RXC, 8'hC0);
    LINE.send_bits({3'h7, 8'h5A, 1'b0}, 10);
    stat(8'h01, 8'h00); // nothing taken while disabled
    bus(1'b1, asc_pkg::OFF_RXC, 8'hC1);
    LINE.glitch();
    LINE.send_bits({3'h7, 8'h5A, 1'b0}, 10);
    wt(20);
    stat(8'h01, 8'h01); // character waiting
    rdc(asc_pkg::OFF_DATA, 8'h5A); // mid-bit sampling
    stat(8'h01, 8'h00); // glitch gave nothing, queue empty
    $display("test rx done");
  endtask

  task automatic t_parity;
    cfg(8'h47, 8'h41, 8'hAA);
    LINE.send_bits({2'h3, 1'b1, 1'b0, 7'h15, 1'b0}, 10);
    wt(20);
    err(8'h10, 8'h10); // parity mismatch flagged
    rdc(asc_pkg::OFF_DATA, 8'h15); // parity bit kept above data
    err(8'h10, 8'h10); // still latched
    bus(1'b1, asc_pkg::OFF_CMD, 8'h01);
    err(8'h10, 8'h00); // cleared by error reset
    $display("test parity done");
  endtask

  // five-bit character at x1, bits moved on falling receive clock
  task automatic t_short;
    cfg(8'h04, 8'h01, 8'hEA);
    LINE.send_x1({6'h3F, 5'h0A, 1'b0}, 7);
    wt(20);
    rdc(asc_pkg::OFF_DATA, 8'hEA); // ones above
    $display("test short x1 done");
  endtask

  task automatic t_ext;
    bus(1'b1, asc_pkg::OFF_ITC, 8'h01);
    i_sync_n <= 1'b0;
    wt(10);
    check({7'h00, o_int}, 8'h01); // lasting sync change
    stat(8'h10, 8'h10); // sync shown inverted
    bus(1'b1, asc_pkg::OFF_CMD, 8'h02);
    wt(2);
    check({7'h00, o_int}, 8'h00); // pending cleared
    $display("test ext status done");
  endtask

  task automatic t_frame;
    cfg(8'h44, 8'hC1, 8'hEA);
    bus(1'b1, asc_pkg::OFF_VEC, 8'h00);
    bus(1'b1, asc_pkg::OFF_ITC, 8'hFC);
    wt(4);
    check({7'h00, o_wait_ready_n}, 8'h01); // not ready, queue empty
    LINE.send_bits({2'h3, 1'b0, 8'h33, 1'b0}, 10);
    wt(20);
    check({7'h00, o_wait_ready_n}, 8'h00); // ready with a char
    err(8'h40, 8'h40); // low stop bit
    check({7'h00, o_int}, 8'h01); // special condition raised
    rdc(asc_pkg::OFF_VEC, 8'h0E); // special receive vector
    rdc(asc_pkg::OFF_DATA, 8'h33); // no false start after it
    err(8'h40, 8'h00); // not latched
    bus(1'b1, asc_pkg::OFF_ITC, 8'h00);
    $display("test framing done");
  endtask

  task automatic t_overrun;
    for (int i = 1; i < 5; i++) begin
      LINE.send_bits({3'h7, 4'(i), 4'(i), 1'b0}, 10);
    end
    wt(20);
    err(8'h20, 8'h20); // overrun latched
    rdc(asc_pkg::OFF_DATA, 8'h11); // oldest kept
    rdc(asc_pkg::OFF_DATA, 8'h22); // second kept
    rdc(asc_pkg::OFF_DATA, 8'h44); // newest overwrote third
    stat(8'h01, 8'h00); // queue drained
    bus(1'b1, asc_pkg::OFF_CMD, 8'h01);
    err(8'h20, 8'h00); // cleared by error reset
    $display("test overrun done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_tx_enable();
    t_tx_parity();
    t_auto_break();
    t_rx();
    t_parity();
    t_short();
    t_frame();
    t_overrun();
    t_ext();
    close_out();
  end

  // tests need about 20000 cycles; cut a hang at 60000
  initial begin
    #6000000;
    bad_count++;
    close_out();
  end
endmodule
